//--- shared/wdog_consts.vh
// Constants for the dual-mode watchdog: register map, field positions, timing
`ifndef WDOG_CONSTS_VH
`define WDOG_CONSTS_VH

// Register byte offsets
`define WD_CTRL_ADDR 4'h0
`define WD_STAT_ADDR 4'h4
`define WD_RESTART_ADDR 4'h8
`define WD_COUNT_ADDR 4'hC

// Control register fields
`define WD_CTRL_INT_EN 0
`define WD_CTRL_RST_EN 1
`define WD_CTRL_CHG_EN 2
`define WD_CTRL_PER_LO 4
`define WD_CTRL_PER_HI 7

// Status register fields
`define WD_STAT_IRQ 0
`define WD_STAT_RSTFLAG 1
`define WD_STAT_FUSE 2
`define WD_STAT_WIN 3

// Restart key written to the restart register
`define WD_RESTART_KEY 32'h0000A5A5

// Change-enable window length in CPU cycles
`define WD_CHG_WINDOW 3'h4

// Change window value that means closed
`define WD_CHG_CLOSED 3'h0

// Shortest timeout in oscillator ticks, and the width it is written in
`define WD_LIMIT_BASE 12'h800
`define WD_LIMIT_BASE_W 12

// Reset values
`define WD_PERIOD_RST 4'h0

`endif

//--- src/dual_mode_watchdog_config.v
// Dual-mode watchdog: interrupt and system-reset modes with timed change protection
//
// Summary of operation
// - With both modes on, an interrupt timeout clears the interrupt-mode enable.
// - A watchdog-caused system reset sets a readable watchdog reset flag.
// - A watchdog-caused system reset leaves the reset-mode enable set.
// - A programmed always-on fuse forces reset mode permanently enabled.
// - Clearing reset-mode enable needs change-enable set in the previous four cycles.
// - Changing the timeout period needs change-enable set in the previous four cycles.
// - Build option: unprogrammed fuse allows plain period writes.
// - Interrupt-mode writes and setting reset-mode take effect at once.
// - The restart instruction clears the count; software issues it regularly.
// - Interrupt mode off and reset mode on gives a plain reset watchdog.
// - With both modes on and the fuse unprogrammed, first timeout interrupts, next timeout resets.
// - Interrupt-mode timeout with global interrupts enabled sets the interrupt flag and requests an interrupt.
// - Count advances once per 128 kHz oscillator tick while enabled.
// - Count clears on every system reset and whenever the watchdog is disabled.
//
// Local design decisions: the register addresses and register access over Wishbone.
`include "wdog_consts.vh"
`default_nettype none

module dual_mode_watchdog_config #(
  parameter PLAIN_PERIOD_WRITE = 0,
  parameter PERIOD_W = 4,
  parameter COUNT_W = 20,
  parameter OSC_TICK_DIV = 195
) (
  // Clock, reset and the strap that names the reset cause
  input wire clk_i,
  input wire rst_i,
  input wire wd_rst_cause_i,
  // Core-side status and events
  input wire always_on_fuse_i,
  input wire global_irq_en_i,
  input wire restart_instruction_i,
  input wire osc_clk_i,
  // Wishbone slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [3:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  // Requests towards the core
  output reg irq_o,
  output reg sys_reset_req_o
);

  // Oscillator clock is sampled as a plain pin: two flops, then an edge detector.
  // Tolerable because the 128 kHz source is far below the 25 MHz CPU clock.
  localparam N_PINS = 2;
  localparam PIN_OSC = 0;
  localparam PIN_FUSE = 1;

  wire [N_PINS-1:0] pin_raw;
  wire [N_PINS-1:0] pin_sync;
  wire osc_sync;
  reg osc_prev_r;
  wire osc_tick;
  wire fuse_on;

  reg int_en_r;
  reg int_en_nxt;
  reg rst_en_r;
  reg rst_en_nxt;
  reg [2:0] chg_cnt_r;
  reg [2:0] chg_cnt_nxt;
  reg [PERIOD_W-1:0] period_r;
  reg [PERIOD_W-1:0] period_nxt;
  reg irq_flag_r;
  reg irq_flag_nxt;
  reg sys_req_nxt;
  reg rst_flag_r;
  reg rst_flag_nxt;
  reg [COUNT_W-1:0] count_r;
  reg [COUNT_W-1:0] count_nxt;
  reg to_meta_r;
  reg to_sync_r;
  reg to_prev_r;
  reg timeout_r;
  reg timeout_nxt;
  reg [31:0] rd_nxt;
  wire timeout_evt;
  wire at_limit;

  wire wb_req;
  wire wb_commit;
  wire wr_ctrl;
  wire wr_restart;
  wire clr_irq;
  wire clr_rst_flag;
  wire chg_open;
  wire rst_en_eff;
  wire wd_active;
  wire plain_period;
  wire [COUNT_W-1:0] limit;

  // Address match for one register, shared by the write and clear decodes below
  function reg_hit;
    input [3:0] adr;
    input [3:0] offset;
    begin
      reg_hit = (adr == offset);
    end
  endfunction

  // Timeout limit in oscillator ticks for a period code: base << code
  function [COUNT_W-1:0] period_limit;
    input [PERIOD_W-1:0] code;
    begin
      period_limit = {{(COUNT_W-`WD_LIMIT_BASE_W){1'b0}}, `WD_LIMIT_BASE} << code;
    end
  endfunction

  // Write-one-to-clear decode of the status register, used for both flags
  function stat_clear;
    input [3:0] adr;
    input [3:0] sel;
    input [31:0] data;
    input integer bit_pos;
    begin
      stat_clear = reg_hit(adr, `WD_STAT_ADDR) && sel[0] && data[bit_pos];
    end
  endfunction

  assign wb_req = cyc_i && stb_i && !ack_o;
  // Writes land on the edge at which the master sees ack, as classic Wishbone expects
  assign wb_commit = cyc_i && stb_i && we_i && ack_o;
  assign wr_ctrl = wb_commit && sel_i[0] && reg_hit(adr_i, `WD_CTRL_ADDR);
  assign wr_restart = wb_commit && reg_hit(adr_i, `WD_RESTART_ADDR) && (dat_i == `WD_RESTART_KEY);
  assign clr_irq = wb_commit && stat_clear(adr_i, sel_i, dat_i, `WD_STAT_IRQ);
  assign clr_rst_flag = wb_commit && stat_clear(adr_i, sel_i, dat_i, `WD_STAT_RSTFLAG);
  assign chg_open = (chg_cnt_r != `WD_CHG_CLOSED);
  assign rst_en_eff = rst_en_r || fuse_on;
  assign wd_active = int_en_r || rst_en_eff;
  assign plain_period = (PLAIN_PERIOD_WRITE != 0) && !fuse_on;
  assign limit = period_limit(period_r);
  assign at_limit = (count_r >= limit - 1'b1);
  assign osc_tick = osc_sync && !osc_prev_r;
  assign timeout_evt = to_sync_r && !to_prev_r;

  assign pin_raw[PIN_OSC] = osc_clk_i;
  assign pin_raw[PIN_FUSE] = always_on_fuse_i;

  // One two-flop synchroniser per pin from outside the CPU clock
  genvar gi;
  generate
    for (gi = 0; gi < N_PINS; gi = gi + 1) begin : g_pin_sync
      reg meta_r;
      reg sync_r;
      always @(posedge clk_i) begin
        meta_r <= pin_raw[gi];
        sync_r <= meta_r;
      end
      assign pin_sync[gi] = sync_r;
    end
  endgenerate

  assign osc_sync = pin_sync[PIN_OSC];
  assign fuse_on = pin_sync[PIN_FUSE];

  // Only the synchronised copy feeds the edge detector
  always @(posedge clk_i) begin
    osc_prev_r <= osc_sync;
  end

  // Watchdog count, advanced on oscillator ticks
  always @* begin
    count_nxt = count_r;
    if (!wd_active || restart_instruction_i || wr_restart) begin
      count_nxt = {COUNT_W{1'b0}};
    end else if (osc_tick) begin
      // Count wraps on the timeout tick so the next period starts at once
      if (at_limit) begin
        count_nxt = {COUNT_W{1'b0}};
      end else begin
        count_nxt = count_r + 1'b1;
      end
    end
  end

  // A restart in the tick cycle cancels the timeout
  always @* begin
    timeout_nxt = 1'b0;
    if (wd_active && osc_tick && at_limit && !restart_instruction_i && !wr_restart) begin
      timeout_nxt = 1'b1;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      count_r <= {COUNT_W{1'b0}};
      timeout_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      timeout_r <= timeout_nxt;
    end
  end

  // Timeout pulse passes two flops before the mode logic acts on it
  always @(posedge clk_i) begin
    if (rst_i) begin
      to_meta_r <= 1'b0;
      to_sync_r <= 1'b0;
      to_prev_r <= 1'b0;
    end else begin
      to_meta_r <= timeout_r;
      to_sync_r <= to_meta_r;
      to_prev_r <= to_sync_r;
    end
  end

  // Next state of the mode bits, change window, period and flags
  always @* begin
    int_en_nxt = int_en_r;
    rst_en_nxt = rst_en_r;
    period_nxt = period_r;
    irq_flag_nxt = irq_flag_r;
    sys_req_nxt = sys_reset_req_o;
    chg_cnt_nxt = chg_cnt_r;
    // Change window counts down and closes by itself
    if (chg_open) begin
      chg_cnt_nxt = chg_cnt_r - 3'h1;
    end
    if (wr_ctrl) begin
      int_en_nxt = dat_i[`WD_CTRL_INT_EN];
      // Only an open window may take reset mode away
      if (dat_i[`WD_CTRL_RST_EN]) begin
        rst_en_nxt = 1'b1;
      end else if (chg_open) begin
        rst_en_nxt = 1'b0;
      end
      if (chg_open || plain_period) begin
        period_nxt = dat_i[`WD_CTRL_PER_HI:`WD_CTRL_PER_LO];
      end
      if (dat_i[`WD_CTRL_CHG_EN]) begin
        chg_cnt_nxt = `WD_CHG_WINDOW;
      end
    end
    // Clear first so that a timeout in the same cycle wins
    if (clr_irq) begin
      irq_flag_nxt = 1'b0;
    end
    if (timeout_evt) begin
      if (int_en_r && !fuse_on) begin
        if (global_irq_en_i) begin
          irq_flag_nxt = 1'b1;
        end
        if (rst_en_eff) begin
          int_en_nxt = 1'b0;
        end
      end else if (rst_en_eff) begin
        sys_req_nxt = 1'b1;
      end
    end
  end

  // Configuration and mode state
  always @(posedge clk_i) begin
    if (rst_i) begin
      int_en_r <= 1'b0;
      chg_cnt_r <= `WD_CHG_CLOSED;
      irq_flag_r <= 1'b0;
      sys_reset_req_o <= 1'b0;
      irq_o <= 1'b0;
      // A reset the watchdog caused keeps reset mode and its period
      if (!wd_rst_cause_i) begin
        rst_en_r <= 1'b0;
        period_r <= `WD_PERIOD_RST;
      end
    end else begin
      int_en_r <= int_en_nxt;
      rst_en_r <= rst_en_nxt;
      period_r <= period_nxt;
      chg_cnt_r <= chg_cnt_nxt;
      irq_flag_r <= irq_flag_nxt;
      sys_reset_req_o <= sys_req_nxt;
      irq_o <= irq_flag_r;
    end
  end

  // Reset flag survives the reset it reports
  always @* begin
    rst_flag_nxt = rst_flag_r;
    if (clr_rst_flag) begin
      rst_flag_nxt = 1'b0;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      rst_flag_r <= wd_rst_cause_i;
    end else begin
      rst_flag_r <= rst_flag_nxt;
    end
  end

  // Read word is assembled here and registered together with ack
  always @* begin
    rd_nxt = 32'h00000000;
    case (adr_i)
      `WD_CTRL_ADDR: begin
        rd_nxt[`WD_CTRL_INT_EN] = int_en_r;
        rd_nxt[`WD_CTRL_RST_EN] = rst_en_eff;
        rd_nxt[`WD_CTRL_CHG_EN] = chg_open;
        rd_nxt[`WD_CTRL_PER_HI:`WD_CTRL_PER_LO] = period_r;
      end
      `WD_STAT_ADDR: begin
        rd_nxt[`WD_STAT_IRQ] = irq_flag_r;
        rd_nxt[`WD_STAT_RSTFLAG] = rst_flag_r;
        rd_nxt[`WD_STAT_FUSE] = fuse_on;
        rd_nxt[`WD_STAT_WIN] = chg_open;
      end
      `WD_COUNT_ADDR: begin
        rd_nxt[COUNT_W-1:0] = count_r;
      end
      default: begin
        rd_nxt = 32'h00000000;
      end
    endcase
  end

  // Wishbone slave: one-cycle-late ack, unmapped reads return zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= wb_req;
      dat_o <= 32'h00000000;
      if (wb_req && !we_i) begin
        dat_o <= rd_nxt;
      end
    end
  end

endmodule

`default_nettype wire

//--- verification/dual_mode_watchdog_config_props.sv
// Port-level assertions for the dual-mode watchdog
`default_nettype none
module dual_mode_watchdog_config_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic global_irq_en_i,
  input wire logic always_on_fuse_i,
  input wire logic ack_o,
  input wire logic irq_o,
  input wire logic sys_reset_req_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence bus_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence irq_rise;
    $rose(irq_o);
  endsequence
  a_ack_follows: assert property (bus_req |=> ack_o) else $error("no ack after request");
  a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
  a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
  a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !ack_o && !irq_o && !sys_reset_req_o)
    else $error("outputs not cleared by reset");
  a_rst_req_holds: assert property (sys_reset_req_o |=> sys_reset_req_o)
    else $error("reset request dropped early");
  a_irq_needs_gie: assert property (irq_rise |-> $past(global_irq_en_i, 2))
    else $error("interrupt with interrupts off");
  a_irq_not_reset: assert property (irq_rise |-> !sys_reset_req_o)
    else $error("first timeout reset the system");
  a_fuse_no_irq: assert property (irq_rise |-> !$past(always_on_fuse_i, 4))
    else $error("interrupt while fuse programmed");
endmodule
bind dual_mode_watchdog_config dual_mode_watchdog_config_props props_i (.clk_i, .rst_i, .cyc_i, .stb_i,
  .global_irq_en_i, .always_on_fuse_i, .ack_o, .irq_o, .sys_reset_req_o);
`default_nettype wire

//--- verification/dual_mode_watchdog_config_test.sv
// Self-checking bench for the dual-mode watchdog
`include "wdog_consts.vh"
`default_nettype none
module dual_mode_watchdog_config_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, rst_i, wd_rst_cause_i, always_on_fuse_i, global_irq_en_i, restart_instruction_i, osc_clk_i;
  logic cyc_i, stb_i, we_i, ack_o, irq_o, sys_reset_req_o;
  logic [3:0] adr_i, sel_i;
  logic [31:0] dat_i, dat_o, q;
  int n_errors, samples_checked;
  dual_mode_watchdog_config dual_mode_watchdog_config_i (.clk_i, .rst_i, .wd_rst_cause_i, .always_on_fuse_i,
    .global_irq_en_i, .restart_instruction_i, .osc_clk_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .irq_o, .sys_reset_req_o);
  initial begin
    clk_i = 1'h0;
    forever #20 clk_i = ~clk_i;
  end
  // Unrelated to the CPU clock so the synchroniser sees drifting phases
  initial begin
    osc_clk_i = 1'h0;
    forever #83 osc_clk_i = ~osc_clk_i;
  end
  task close_out;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task fail_out;
    n_errors++;
    close_out;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    for (k = 0; ack_o !== 1'h1; k++) begin
      if (k == 20) fail_out;
      @(posedge clk_i);
    end
    q = dat_o;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
  endtask
  task wait_out(input logic rs);
    int k;
    for (k = 0; (rs ? sys_reset_req_o : irq_o) !== 1'h1; k++) begin
      if (k == 40000) fail_out;
      @(posedge clk_i);
    end
  endtask
  task t_reset_vals;
    wb(1'h0, `WD_CTRL_ADDR, 32'h0);
    chk("ctrl", 32'h0, q);
    wb(1'h0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, q);
    wb(1'h0, `WD_STAT_ADDR, 32'h0);
    chk("stat", 32'h0, q);
  endtask
  task t_window;
    wb(1'h1, `WD_CTRL_ADDR, 32'h2);
    wb(1'h0, `WD_CTRL_ADDR, 32'h0);
    chk("ctrl", 32'h2, q);
    wb(1'h1, `WD_CTRL_ADDR, 32'h0);
    wb(1'h0, `WD_CTRL_ADDR, 32'h0);
    chk("ctrl", 32'h2, q);
    wb(1'h1, `WD_CTRL_ADDR, 32'h6);
    wb(1'h1, `WD_CTRL_ADDR, 32'h10);
    wb(1'h0, `WD_CTRL_ADDR, 32'h0);
    chk("ctrl", 32'h10, q);
    wb(1'h1, `WD_CTRL_ADDR, 32'h20);
    wb(1'h0, `WD_CTRL_ADDR, 32'h0);
    chk("ctrl", 32'h10, q);
  endtask
  task t_fuse;
    always_on_fuse_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    wb(1'h1, `WD_CTRL_ADDR, 32'h4);
    wb(1'h1, `WD_CTRL_ADDR, 32'h10);
    wb(1'h0, `WD_CTRL_ADDR, 32'h0);
    chk("ctrl", 32'h2, q & 32'h2);
    always_on_fuse_i <= 1'h0;
    repeat (3) @(posedge clk_i);
  endtask
  task t_combined;
    wb(1'h1, `WD_RESTART_ADDR, `WD_RESTART_KEY);
    wb(1'h1, `WD_CTRL_ADDR, 32'h13);
    wait_out(1'h0);
    chk("rst req", 32'h0, {31'h0, sys_reset_req_o});
    wb(1'h0, `WD_CTRL_ADDR, 32'h0);
    chk("ctrl", 32'h12, q);
    wait_out(1'h1);
    rst_i <= 1'h1;
    wd_rst_cause_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    wd_rst_cause_i <= 1'h0;
    wb(1'h0, `WD_CTRL_ADDR, 32'h0);
    chk("ctrl", 32'h12, q);
    wb(1'h0, `WD_STAT_ADDR, 32'h0);
    chk("stat", 32'h2, q & 32'h2);
  endtask
  task t_wakeup;
    global_irq_en_i <= 1'h0;
    wb(1'h1, `WD_STAT_ADDR, 32'h2);
    wb(1'h1, `WD_CTRL_ADDR, 32'h14);
    wb(1'h1, `WD_CTRL_ADDR, 32'h10);
    global_irq_en_i <= 1'h1;
    wb(1'h0, `WD_CTRL_ADDR, 32'h0);
    chk("ctrl", 32'h10, q);
    wb(1'h0, `WD_STAT_ADDR, 32'h0);
    chk("stat", 32'h0, q & 32'h2);
    wb(1'h0, `WD_COUNT_ADDR, 32'h0);
    chk("count", 32'h0, q);
    wb(1'h1, `WD_CTRL_ADDR, 32'h11);
    repeat (40) @(posedge clk_i);
    restart_instruction_i <= 1'h1;
    @(posedge clk_i);
    restart_instruction_i <= 1'h0;
    wb(1'h0, `WD_COUNT_ADDR, 32'h0);
    chk("count small", 32'h1, {31'h0, q < 32'h4});
    wait_out(1'h0);
    wb(1'h0, `WD_CTRL_ADDR, 32'h0);
    chk("ctrl", 32'h11, q);
    wb(1'h1, `WD_STAT_ADDR, 32'h1);
    wb(1'h0, `WD_STAT_ADDR, 32'h0);
    chk("stat", 32'h0, q & 32'h1);
  endtask
  initial begin
    {rst_i, wd_rst_cause_i, always_on_fuse_i, restart_instruction_i} = 4'h8;
    {cyc_i, stb_i, we_i, global_irq_en_i} = 4'h1;
    {adr_i, sel_i, dat_i} = {8'h0F, 32'h0};
    repeat (12) @(posedge clk_i);
    rst_i <= 1'h0;
    t_reset_vals;
    t_window;
    t_fuse;
    t_combined;
    t_wakeup;
    close_out;
  end
endmodule
`default_nettype wire
